// >>> src/dtsd_pkg.sv
// constants and types shared by the tone decoder back end
package dtsd_pkg;
    // system clock rate in hertz
    localparam int unsigned CLK_HZ = 40000000;
    // tone timing reference rate in hertz
    localparam int unsigned REF_HZ = 4194304;
    // presence qualification time in microseconds, inside 5 ms .. 20 ms
    localparam int unsigned PRESENCE_US = 12000;
    // absence qualification time in microseconds, inside 0.5 ms .. 15 ms
    localparam int unsigned ABSENCE_US = 5000;
    // reference ticks for each qualification time
    localparam longint unsigned PRESENCE_TICKS = 64'(REF_HZ) * 64'(PRESENCE_US) / 64'd1000000;
    localparam longint unsigned ABSENCE_TICKS = 64'(REF_HZ) * 64'(ABSENCE_US) / 64'd1000000;
    // width of the phase accumulator of the reference divider
    localparam int unsigned ACC_W = 26;
    // width of the qualification counters
    localparam int unsigned CNT_W = 17;
    // bits in one symbol code
    localparam int unsigned CODE_W = 4;
    // width of the readout pulse counter
    localparam int unsigned BITCNT_W = 3;
    // readout pulses per symbol
    localparam logic [2:0] READ_PULSES = 3'h4;
    // sampled pin vector: ack, present, row[1:0], col[1:0]
    localparam int unsigned PIN_W = 6;
    localparam int unsigned PIN_ACK = 5;
    localparam int unsigned PIN_PRES = 4;
    localparam int unsigned PIN_ROW = 2;
    localparam int unsigned PIN_COL = 0;
    // row and column index of the fourth row tone and of the fourth column tone
    localparam logic [1:0] LAST_IDX = 2'h3;
    // reset value of the symbol code
    localparam logic [3:0] CODE_RST = 4'h0;

    // tone qualification states
    typedef enum logic [2:0] {
        DTSD_IDLE  = 3'b001,
        DTSD_QUAL  = 3'b010,
        DTSD_STEER = 3'b100
    } dtsd_state_e;
endpackage

// >>> src/dtsd_sync.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dtsd_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level
);
    // all sync state in one record
    typedef struct packed {
        logic [WIDTH-1:0] s1;   // first stage, read only by s2
        logic [WIDTH-1:0] s2;   // second stage
        logic [WIDTH-1:0] s3;   // third stage
        logic [WIDTH-1:0] held; // accepted level
    } dtsd_sync_s;

    dtsd_sync_s q;
    dtsd_sync_s next_q;

    // shift pins in, accept a bit once stages two and three agree
    always_comb begin
        next_q = q;
        next_q.s1 = pin_in;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                next_q.held[i] = q.s3[i];
            end
        end
    end

    // register the record
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign level = q.held;
endmodule
`default_nettype wire

// >>> src/dtsd_decoder.sv
// digital back end of the dual tone receiver: qualification and serial readout
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - sixteen symbols, delivered as four bit code
// - steering flag high while valid symbol
// - flag rises 5 to 20 ms after tone
// - flag falls 0.5 to 15 ms after loss
// - code shifted out on shift pulses
// - first pulse edge captures the symbol
// - timing derived from 4.194304 MHz reference
// - lsb on first edge, then higher bits
// - extra pulses ignored until next flag
// - symbol to code mapping table
module dtsd_decoder #(
    parameter int unsigned PRESENCE_CNT = 32'(dtsd_pkg::PRESENCE_TICKS),
    parameter int unsigned ABSENCE_CNT = 32'(dtsd_pkg::ABSENCE_TICKS)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tone_present,      // digital detector: valid pair seen
    input wire logic [1:0] tone_row,    // low group index, 697 Hz = 0
    input wire logic [1:0] tone_col,    // high group index, 1209 Hz = 0
    input wire logic shift_pulse,       // host acknowledge pulse pin
    output logic early_steering_flag,
    output logic serial_code_out
);
    // whole module state
    typedef struct packed {
        dtsd_pkg::dtsd_state_e state;                  // qualification state
        logic [dtsd_pkg::ACC_W-1:0] acc;               // reference phase accumulator
        logic tick;                                    // reference clock enable
        logic [dtsd_pkg::CNT_W-1:0] cnt;               // presence or absence ticks
        logic flag;                                    // steering flag
        logic [dtsd_pkg::CODE_W-1:0] code;             // latched symbol code
        logic [dtsd_pkg::CODE_W-1:0] shreg;            // output shift register
        logic [dtsd_pkg::BITCNT_W-1:0] bit_cnt;        // pulses taken
        logic sout;                                    // serial output bit
        logic ack_prev;                                // last accepted pulse level
    } dtsd_s;

    dtsd_s q;
    dtsd_s next_q;
    logic [dtsd_pkg::PIN_W-1:0] pins;    // filtered pin levels
    logic pres;                          // filtered tone presence
    logic ack_rise;                      // rising pulse edge, one cycle
    logic [dtsd_pkg::ACC_W:0] acc_sum;   // accumulator plus step

    // every pin enters through the three stage filter
    dtsd_sync #(
        .WIDTH(dtsd_pkg::PIN_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin_in({shift_pulse, tone_present, tone_row, tone_col}),
        .level(pins)
    );

    // map row and column to code; D wraps to zero in four bits
    function automatic logic [3:0] dtsd_encode(input logic [1:0] r, input logic [1:0] c);
        logic [3:0] v;
        v = 4'h0;
        if (c == dtsd_pkg::LAST_IDX) begin
            v = 4'hD + {2'h0, r};
        end else if (r != dtsd_pkg::LAST_IDX) begin
            v = 4'({2'h0, r} * 4'h3) + {2'h0, c} + 4'h1;
        end else begin
            unique case (c)
                2'h0: v = 4'hB;                            // star
                2'h1: v = 4'hA;                            // zero
                default: v = 4'hC;                         // hash
            endcase
        end
        return v;
    endfunction

    assign pres = pins[dtsd_pkg::PIN_PRES];
    assign ack_rise = pins[dtsd_pkg::PIN_ACK] & ~q.ack_prev;
    assign acc_sum = {1'b0, q.acc} + 27'(dtsd_pkg::REF_HZ);

    // next state
    always_comb begin
        next_q = q;
        next_q.ack_prev = pins[dtsd_pkg::PIN_ACK];
        // fractional divider: 4.194304 MHz enable from 40 MHz
        next_q.tick = 1'b0;
        if (acc_sum >= 27'(dtsd_pkg::CLK_HZ)) begin
            next_q.acc = dtsd_pkg::ACC_W'(acc_sum - 27'(dtsd_pkg::CLK_HZ));
            next_q.tick = 1'b1;
        end else begin
            next_q.acc = acc_sum[dtsd_pkg::ACC_W-1:0];
        end
        // qualification; guard time is left to the host
        unique case (q.state)
            dtsd_pkg::DTSD_IDLE: begin
                next_q.cnt = '0;
                if (pres) begin
                    next_q.state = dtsd_pkg::DTSD_QUAL;
                end
            end
            dtsd_pkg::DTSD_QUAL: begin
                if (!pres) begin
                    // tone broke before qualifying
                    next_q.state = dtsd_pkg::DTSD_IDLE;
                    next_q.cnt = '0;
                end else if (q.tick) begin
                    if (q.cnt == dtsd_pkg::CNT_W'(PRESENCE_CNT - 1)) begin
                        next_q.state = dtsd_pkg::DTSD_STEER;
                        next_q.flag = 1'b1;
                        next_q.cnt = '0;
                        next_q.code = dtsd_encode(pins[dtsd_pkg::PIN_ROW +: 2],
                                                  pins[dtsd_pkg::PIN_COL +: 2]);
                        next_q.bit_cnt = '0;                                   // rearm
                    end else begin
                        next_q.cnt = q.cnt + 1'b1;
                    end
                end
            end
            dtsd_pkg::DTSD_STEER: begin
                if (pres) begin
                    // any returning tone restarts the absence window
                    next_q.cnt = '0;
                end else if (q.tick) begin
                    if (q.cnt == dtsd_pkg::CNT_W'(ABSENCE_CNT - 1)) begin
                        next_q.state = dtsd_pkg::DTSD_IDLE;
                        next_q.flag = 1'b0;
                        next_q.cnt = '0;
                    end else begin
                        next_q.cnt = q.cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_q.state = dtsd_pkg::DTSD_IDLE;
                next_q.flag = 1'b0;
            end
        endcase
        // readout; a short readout leaves the count stale until rearm
        if (ack_rise) begin
            if (q.bit_cnt == '0) begin
                if (q.flag) begin
                    next_q.shreg = q.code;
                    next_q.sout = q.code[0];
                    next_q.bit_cnt = 3'h1;
                end
            end else if (q.bit_cnt < dtsd_pkg::READ_PULSES) begin
                next_q.sout = q.shreg[q.bit_cnt[1:0]];
                next_q.bit_cnt = q.bit_cnt + 3'h1;
            end
            // fifth and later pulses change nothing
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{state: dtsd_pkg::DTSD_IDLE, acc: '0, tick: 1'b0, cnt: '0, flag: 1'b0,
                   code: dtsd_pkg::CODE_RST, shreg: dtsd_pkg::CODE_RST,
                   bit_cnt: dtsd_pkg::READ_PULSES, sout: 1'b0, ack_prev: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign early_steering_flag = q.flag;
    assign serial_code_out = q.sout;

    // flag mirrors the steering state
    a_flag_state: assert property (@(posedge clk) disable iff (rst)
        q.flag == (q.state == dtsd_pkg::DTSD_STEER))
        else $error("steering flag out of step with state");

    // flag rises only after a full presence count with tone held
    a_flag_rise: assert property (@(posedge clk) disable iff (rst)
        $rose(q.flag) |-> $past(q.state) == dtsd_pkg::DTSD_QUAL && $past(pres)
            && $past(q.cnt) == dtsd_pkg::CNT_W'(PRESENCE_CNT - 1))
        else $error("steering flag rose without full presence time");

    // flag falls only after the absence count with tone gone
    a_flag_fall: assert property (@(posedge clk) disable iff (rst)
        $fell(q.flag) |-> !$past(pres) && $past(q.cnt) == dtsd_pkg::CNT_W'(ABSENCE_CNT - 1))
        else $error("steering flag fell without full absence time");

    // reference enable never closer than nine system cycles
    a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
        q.tick |=> (!q.tick) [*8])
        else $error("reference enable too frequent");

    // reference enable repeats every nine or ten cycles, so timing tracks the reference
    a_tick_period: assert property (@(posedge clk) disable iff (rst)
        q.tick |-> ##[9:10] q.tick)
        else $error("reference enable period wrong");

    // serial bit moves only on an accepted pulse
    a_sout_hold: assert property (@(posedge clk) disable iff (rst)
        !ack_rise |=> $stable(q.sout))
        else $error("serial bit changed without a pulse");

    // flag stays up while the tone stays
    a_flag_hold: assert property (@(posedge clk) disable iff (rst)
        q.flag && pres |=> q.flag)
        else $error("steering flag dropped with tone present");

    // first pulse captures code and shows the lsb
    a_capture_lsb: assert property (@(posedge clk) disable iff (rst)
        ack_rise && q.bit_cnt == 3'h0 && q.flag |=> q.sout == $past(q.code[0])
            && q.shreg == $past(q.code) && q.bit_cnt == 3'h1)
        else $error("first pulse did not capture the symbol");

    // later pulses present the next higher bit
    a_shift_next: assert property (@(posedge clk) disable iff (rst)
        ack_rise && q.bit_cnt != 3'h0 && q.bit_cnt < 3'h4
            |=> q.sout == $past(q.shreg[q.bit_cnt[1:0]]) && q.bit_cnt == $past(q.bit_cnt) + 3'h1)
        else $error("shift pulse did not advance the bit");

    // pulses past the fourth leave the output alone
    a_ignore_extra: assert property (@(posedge clk) disable iff (rst)
        q.bit_cnt == 3'h4 && ack_rise |=> $stable(q.sout) && $stable(q.shreg))
        else $error("extra shift pulse changed the output");

    // pulse counter stays within four
    a_count_range: assert property (@(posedge clk) disable iff (rst)
        q.bit_cnt <= 3'h4)
        else $error("pulse counter out of range");

    // symbol D codes as zero, hash as twelve
    a_encode_map: assert property (@(posedge clk) disable iff (rst)
        $rose(q.flag) |-> q.code == ($past(pins[3:0]) == 4'hF ? 4'h0
            : $past(pins[3:0]) == 4'hE ? 4'hC : q.code))
        else $error("symbol encoded wrongly");
endmodule
`default_nettype wire

// >>> verification/dtsd_host_model.sv
// host side model: judges the steering flag and pulses the acknowledge pin
`timescale 1ns/1ps
`default_nettype none
module dtsd_host_model (
    input wire logic clk,
    input wire logic early_steering_flag,
    input wire logic serial_code_out,
    output logic shift_pulse
);
    // pin idles low between readouts
    initial shift_pulse = 1'b0;

    // one 200 ns pulse, 4 clk high and 4 low; bit taken before the next rise
    task automatic pulse(output logic b);
        shift_pulse <= 1'b1;
        repeat (4) @(posedge clk);
        shift_pulse <= 1'b0;
        repeat (4) @(posedge clk);
        b = serial_code_out;
    endtask

    // a readout is n pulses, as the caller asks, lsb arrives first
    task automatic read_code(input int n, output logic [3:0] code);
        logic b;
        code = 4'h0;
        for (int i = 0; i < n; i++) begin
            pulse(b);
            code[i] = b;
        end
    endtask

    // guard time is judged here by counting flag cycles, not in the device
    task automatic wait_flag(input logic level, input int limit, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (early_steering_flag !== level && n < limit);
    endtask
endmodule
`default_nettype wire

// >>> verification/dual_tone_serial_decoder_tb.sv
// self checking bench for the tone decoder back end
`timescale 1ns/1ps
`default_nettype none
module dual_tone_serial_decoder_tb;
    localparam int unsigned PRES = 20; // shortened presence count
    localparam int unsigned ABS = 10; // shortened absence count
    // expected qualify delays in clk, from the reference tick rate
    localparam int unsigned PRES_CLK = PRES * dtsd_pkg::CLK_HZ / dtsd_pkg::REF_HZ;
    localparam int unsigned ABS_CLK = ABS * dtsd_pkg::CLK_HZ / dtsd_pkg::REF_HZ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tone_present = 1'b0;
    logic [1:0] tone_row = 2'h0;
    logic [1:0] tone_col = 2'h0;
    wire logic flag;
    wire logic sdo;
    wire logic shift_pulse;
    int err_total = 0;
    int samples_checked = 0;

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    dtsd_decoder #(.PRESENCE_CNT(PRES), .ABSENCE_CNT(ABS)) u_dut (
        .clk(clk),
        .rst(rst),
        .tone_present(tone_present),
        .tone_row(tone_row),
        .tone_col(tone_col),
        .shift_pulse(shift_pulse),
        .early_steering_flag(flag),
        .serial_code_out(sdo)
    );

    dtsd_host_model u_host (
        .clk(clk),
        .early_steering_flag(flag),
        .serial_code_out(sdo),
        .shift_pulse(shift_pulse)
    );

    // case equality so an unknown never matches
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // codes of all sixteen pairs as a plain table, nibble index {row, col}
    localparam logic [63:0] CODE_TABLE = 64'h0CAB_F987_E654_D321;

    // code of a row and column tone pair, looked up rather than computed
    function automatic logic [3:0] exp_code(input logic [1:0] r, input logic [1:0] c);
        return CODE_TABLE[4 * int'({r, c}) +: 4];
    endfunction

    // reset levels, a stray pulse, and a tone too short to qualify
    task automatic t_idle();
        logic b;
        int n;
        check(4'({flag, sdo}), 4'h0, "reset levels");
        u_host.pulse(b);
        check(4'(b), 4'h0, "stray pulse");
        tone_present <= 1'b1;
        repeat (100) @(posedge clk);
        tone_present <= 1'b0;
        u_host.wait_flag(1'b1, 300, n);
        check(4'(n == 300), 4'h1, "short tone");
    endtask

    // one symbol: qualify, read four bits, one extra pulse, then absence
    task automatic t_symbol(input logic [1:0] r, input logic [1:0] c);
        int n;
        logic [3:0] code;
        logic [3:0] want;
        logic b;
        want = exp_code(r, c);
        tone_row <= r;
        tone_col <= c;
        tone_present <= 1'b1;
        u_host.wait_flag(1'b1, 400, n);
        check(4'(n >= PRES_CLK - 8 && n <= PRES_CLK + 24), 4'h1, "presence");
        u_host.read_code(4, code);
        check(code, want, "symbol code");
        u_host.pulse(b);
        check(4'(b), 4'(want[3]), "fifth pulse");
        check(4'(flag), 4'h1, "flag during tone");
        tone_present <= 1'b0;
        u_host.wait_flag(1'b0, 300, n);
        check(4'(n >= ABS_CLK - 8 && n <= ABS_CLK + 24), 4'h1, "absence");
        repeat (10) @(posedge clk);
    endtask

    // reset in mid readout: outputs clear and the pulse counter is disarmed again
    task automatic t_reset();
        int n;
        logic b;
        tone_row <= 2'h0;
        tone_col <= 2'h0;
        tone_present <= 1'b1;
        u_host.wait_flag(1'b1, 400, n);
        check(4'(n < 400), 4'h1, "flag before reset");
        u_host.pulse(b);
        check(4'(b), 4'h1, "first bit before reset");
        tone_present <= 1'b0;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(4'({flag, sdo}), 4'h0, "levels after reset");
        u_host.pulse(b);
        check(4'(b), 4'h0, "pulse after reset");
    endtask

    // main sequence: reset, idle checks, all sixteen tone pairs, mid run reset
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_idle();
        for (int i = 0; i < 16; i++) begin
            t_symbol(2'(i / 4), 2'(i % 4));
        end
        t_reset();
        end_sim();
    end

    // watchdog well past the roughly 6200 clk the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
